//--- dv/mode_table_model.sv
`timescale 1ns/10ps
`default_nettype none
// stand-in mode decode: the upper half of the mode space is 64b/66b;
// only the 64b/66b flag, E and F reach the block, the real table is not modelled
module mode_table_model (
  input  wire logic [5:0] mode_i,
  output logic            is_64b66b_o,
  output logic [3:0]      e_o,
  output logic [4:0]      f_o
);
  always_comb begin
    is_64b66b_o = mode_i[5];
    e_o = 4'h1 + {2'h0, mode_i[1:0]};
    f_o = 5'h08;
  end
endmodule
`default_nettype wire

//--- dv/serial_link_checker.sv
`timescale 1ns/10ps
`default_nettype none
module serial_link_checker #(
  parameter int ADC_W    = 12,
  parameter int SAMPLE_N = 16
) (
  input wire logic                            clk_i,
  input wire logic                            sys_rst_i,
  input wire logic [11:0]                     reg_addr_i,
  input wire logic [7:0]                      reg_wdata_i,
  input wire logic                            reg_wr_i,
  input wire logic                            timestamp_receiver_enable_i,
  input wire logic [ADC_W-1:0]                sample_i,
  input wire logic                            sample_valid_i,
  input wire logic [SAMPLE_N-1:0]             sample_o,
  input wire logic                            sample_valid_o,
  input wire logic                            link_reset_o,
  input wire logic                            serializer_powerdown_o,
  input wire logic                            link_clock_enable_o,
  input wire logic                            lmfc_counter_reset_o,
  input wire logic                            sysref_align_enable_o,
  input wire logic                            link_start_o,
  input wire logic [5:0]                      link_output_mode_o,
  input wire logic [serial_link_pkg::K_W-1:0] effective_k_minus_one_o,
  input wire logic [1:0]                      ilas_control_bits_o
);
  // one clock domain, so one default for all properties
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  logic en_wr;
  assign en_wr = reg_wr_i &&
    (reg_addr_i == serial_link_pkg::ADDR_LINK_SUBSYSTEM_ENABLE);

  // start is one cycle, straight out of the disabled state, then running
  sequence s_start_from_off;
    $past(link_reset_o) && link_start_o ##1 !link_start_o && !link_reset_o;
  endsequence

  a_ilas_cs_zero: assert property (ilas_control_bits_o == 2'h0)
    else $error("ilas control bits not zero");
  a_off_gates_all: assert property (link_reset_o |->
    serializer_powerdown_o && !link_clock_enable_o)
    else $error("disabled link not powered down");
  a_lmfc_held: assert property (link_reset_o |->
    lmfc_counter_reset_o && !sysref_align_enable_o)
    else $error("lmfc counter not held while disabled");
  a_sample_field: assert property (!$past(sys_rst_i) |->
    sample_o[SAMPLE_N-1:1] == {$past(sample_i), {(SAMPLE_N-ADC_W-1){1'b0}}})
    else $error("sample field misplaced");
  a_marker_gated: assert property (!timestamp_receiver_enable_i [*8]
    |=> sample_o[0] == 1'b0)
    else $error("marker without receiver enable");
  a_valid_running: assert property (sample_valid_o |->
    $past(sample_valid_i) && !$past(link_reset_o) && !$past(link_start_o))
    else $error("sample valid outside running");
  a_disable_delay: assert property (en_wr && !reg_wdata_i[0] &&
    !link_reset_o && !link_start_o |-> ##2 link_reset_o)
    else $error("link not disabled two cycles after write");
  a_enable_start: assert property (en_wr && reg_wdata_i[0] &&
    link_reset_o |-> ##2 link_start_o)
    else $error("link not started two cycles after write");
  a_start_pulse: assert property (link_start_o |-> s_start_from_off)
    else $error("start pulse malformed");
  a_config_frozen: assert property (!link_reset_o && !link_start_o &&
    !$past(link_start_o) |-> $stable(link_output_mode_o) &&
    $stable(effective_k_minus_one_o))
    else $error("mode or k changed while running");
endmodule

bind serial_link_control_regs serial_link_checker #(
  .ADC_W(ADC_W),
  .SAMPLE_N(SAMPLE_N)
) i_serial_link_checker (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .timestamp_receiver_enable_i(timestamp_receiver_enable_i),
  .sample_i(sample_i), .sample_valid_i(sample_valid_i),
  .sample_o(sample_o), .sample_valid_o(sample_valid_o),
  .link_reset_o(link_reset_o), .serializer_powerdown_o(serializer_powerdown_o),
  .link_clock_enable_o(link_clock_enable_o),
  .lmfc_counter_reset_o(lmfc_counter_reset_o),
  .sysref_align_enable_o(sysref_align_enable_o),
  .link_start_o(link_start_o), .link_output_mode_o(link_output_mode_o),
  .effective_k_minus_one_o(effective_k_minus_one_o),
  .ilas_control_bits_o(ilas_control_bits_o)
);
`default_nettype wire

//--- dv/serial_link_control_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("BAD %0t got %0h want %0h", $time, a, b); end end
module serial_link_control_regs_tb;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [11:0] reg_addr_i = 12'h000;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        cal_i = 1'b1;
  logic        recv_i = 1'b0;
  logic        pin_i = 1'b0;
  logic [11:0] sample_i = 12'h000;
  logic        valid_i = 1'b0;
  logic [7:0]  rdata;
  logic [15:0] sample_o;
  logic        valid_o, rst_o, pd_o, cke_o, lmfc_o, sref_o, start_o, is64;
  logic [5:0]  mode_o;
  logic [11:0] k_o;
  logic [1:0]  cs_o;
  logic [3:0]  e;
  logic [4:0]  f;
  int          failures = 0;
  int          check_count = 0;
  logic [11:0] addrs [4] = '{12'h160, 12'h200, 12'h201, 12'h202};
  logic [7:0]  rst_vals [4] = '{8'h00, 8'h01, 8'h00, 8'h1F};

  always #2.5 clk_i = ~clk_i;

  serial_link_control_regs i_serial_link_control_regs (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(rdata), .cal_enable_i(cal_i),
    .timestamp_receiver_enable_i(recv_i), .timestamp_pin_i(pin_i),
    .mode_is_64b66b_i(is64), .mode_e_i(e), .mode_f_i(f),
    .sample_i(sample_i), .sample_valid_i(valid_i), .sample_o(sample_o),
    .sample_valid_o(valid_o), .link_reset_o(rst_o),
    .serializer_powerdown_o(pd_o), .link_clock_enable_o(cke_o),
    .lmfc_counter_reset_o(lmfc_o), .sysref_align_enable_o(sref_o),
    .link_start_o(start_o), .link_output_mode_o(mode_o),
    .effective_k_minus_one_o(k_o), .ilas_control_bits_o(cs_o));

  mode_table_model i_mode_table_model (
    .mode_i(mode_o), .is_64b66b_o(is64), .e_o(e), .f_o(f));

  // write: one strobe cycle, returns just after the taking edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // read: data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] want);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK(rdata, want)
  endtask

  // enable write to start pulse is two edges
  task automatic restart();
    wr(12'h200, 8'h00);
    wr(12'h200, 8'h01);
    @(posedge clk_i);
    #1;
    `CHK(start_o, 1'b1)
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // whole run is well under 2000 cycles
  initial begin
    repeat (2000) @(posedge clk_i);
    failures++;
    summarize();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    valid_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    `CHK(rst_o, 1'b0)
    for (int i = 0; i < 4; i++)
      rd_chk(addrs[i], rst_vals[i]);
    wr(12'h300, 8'h5A);
    rd_chk(12'h300, 8'h00);
    // disabled: everything held and gated
    wr(12'h200, 8'h00);
    repeat (2) @(posedge clk_i);
    #1;
    `CHK({rst_o, pd_o, cke_o, valid_o}, 4'b1100)
    `CHK({lmfc_o, sref_o}, 2'b10)
    rd_chk(12'h200, 8'h00);
    wr(12'h202, 8'h0B);
    wr(12'h160, 8'h01);
    rd_chk(12'h160, 8'h01);
    wr(12'h200, 8'h01);
    @(posedge clk_i);
    #1;
    `CHK(start_o, 1'b1)
    @(posedge clk_i);
    #1;
    `CHK(k_o, 12'h00B)
    // mode changes only with link and calibration both off
    wr(12'h200, 8'h00);
    cal_i <= 1'b0;
    wr(12'h201, 8'h21);
    rd_chk(12'h201, 8'h21);
    `CHK(mode_o, 6'h00)
    @(posedge clk_i);
    cal_i <= 1'b1;
    // decoded E and F follow the frozen mode; K is ready once running
    restart();
    restart();
    @(posedge clk_i);
    #1;
    `CHK(mode_o, 6'h21)
    `CHK(k_o, 12'h03F)
    @(posedge clk_i);
    recv_i <= 1'b1;
    pin_i <= 1'b1;
    sample_i <= 12'hABC;
    repeat (12) @(posedge clk_i);
    #1;
    `CHK(sample_o, 16'hABC1)
    `CHK(valid_o, 1'b1)
    `CHK(cs_o, 2'h0)
    @(posedge clk_i);
    recv_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    #1;
    `CHK(sample_o, 16'hABC0)
    summarize();
  end
endmodule
`default_nettype wire

//--- src/serial_link_control_regs.sv
// Operation
// - timestamp insert enable puts marker on LSB
// - timestamp latency matches converter sample latency
// - marker at N-field LSB, keeps converter bits when N is wider than ADC_W
// - ILA always reports zero control bits
// - link enable: 0 off, 1 on, resets 1
// - disabled: reset, serializers down, clocks gated
// - disabled: LMFC counter reset, SYSREF ignored
// - 6-bit output mode, change while both off
// - K minus one register, resets 0x1F
// - 64B/66B modes use K = 256*E/F
`timescale 1ns/10ps
`default_nettype none
module serial_link_control_regs #(
  parameter int ADC_W      = 12,
  parameter int SAMPLE_N   = 16,
  parameter int TS_DELAY   = 4,
  parameter int E_W        = 4,
  parameter int F_W        = 5
) (
  input  wire logic                clk_i,
  input  wire logic                sys_rst_i,
  // register port
  input  wire logic [11:0]         reg_addr_i,
  input  wire logic [7:0]          reg_wdata_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  output logic      [7:0]          reg_rdata_o,
  // neighbouring control state
  input  wire logic                cal_enable_i,
  input  wire logic                timestamp_receiver_enable_i,
  input  wire logic                timestamp_pin_i,
  // decoded parameters of the selected mode
  input  wire logic                mode_is_64b66b_i,
  input  wire logic [E_W-1:0]      mode_e_i,
  input  wire logic [F_W-1:0]      mode_f_i,
  // sample path
  input  wire logic [ADC_W-1:0]    sample_i,
  input  wire logic                sample_valid_i,
  output logic      [SAMPLE_N-1:0] sample_o,
  output logic                     sample_valid_o,
  // link subsystem controls
  output logic                     link_reset_o,
  output logic                     serializer_powerdown_o,
  output logic                     link_clock_enable_o,
  output logic                     lmfc_counter_reset_o,
  output logic                     sysref_align_enable_o,
  output logic                     link_start_o,
  output logic [5:0]               link_output_mode_o,
  output logic [serial_link_pkg::K_W-1:0] effective_k_minus_one_o,
  output logic [1:0]               ilas_control_bits_o
);

  // software registers
  logic       timestamp_insert_enable_reg;
  logic       timestamp_insert_enable_next;
  logic       link_subsystem_enable_reg;
  logic       link_subsystem_enable_next;
  logic [5:0] link_output_mode_reg;
  logic [5:0] link_output_mode_next;
  logic [7:0] multiframe_length_minus_one_reg;
  logic [7:0] multiframe_length_minus_one_next;
  logic       order_error_reg;
  logic       order_error_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // link state and captured configuration
  serial_link_pkg::link_state_t state_reg;
  serial_link_pkg::link_state_t state_next;
  logic [5:0]                   active_mode_reg;
  logic [5:0]                   active_mode_next;
  logic [serial_link_pkg::K_W-1:0] active_k_reg;
  logic [serial_link_pkg::K_W-1:0] active_k_next;
  logic                         cal_enable_d_reg;

  // sample path
  logic                sync1_reg;
  logic                sync2_reg;
  logic                ts_delayed;
  logic [SAMPLE_N-1:0] sample_reg;
  logic [SAMPLE_N-1:0] sample_next;
  logic                sample_valid_reg;
  logic                sample_valid_next;
  logic [SAMPLE_N-1:0] sample_placed;

  // address decode, shared by the write and read paths
  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    hit = (a == b);
  endfunction

  // K for 64B/66B modes; F of zero would be an illegal mode, so guard it
  function automatic logic [serial_link_pkg::K_W-1:0] k_from_ef(
    input logic [E_W-1:0] e,
    input logic [F_W-1:0] f
  );
    logic [serial_link_pkg::K_W+E_W-1:0] num;
    logic [serial_link_pkg::K_W+E_W-1:0] quo;
    num = (serial_link_pkg::K_W+E_W)'(serial_link_pkg::K_64B66B_SCALE)
          * (serial_link_pkg::K_W+E_W)'(e);
    quo = (f == '0) ? '0 : num / (serial_link_pkg::K_W+E_W)'(f);
    k_from_ef = (quo == '0) ? '0
              : serial_link_pkg::K_W'(quo - 1'b1);
  endfunction

  // register writes; reserved bits are simply not stored
  always_comb begin
    timestamp_insert_enable_next     = timestamp_insert_enable_reg;
    link_subsystem_enable_next       = link_subsystem_enable_reg;
    link_output_mode_next            = link_output_mode_reg;
    multiframe_length_minus_one_next = multiframe_length_minus_one_reg;
    order_error_next                 = order_error_reg;
    if (reg_wr_i) begin
      if (hit(reg_addr_i, serial_link_pkg::ADDR_TIMESTAMP_LSB_CONTROL)) begin
        timestamp_insert_enable_next =
          reg_wdata_i[serial_link_pkg::TIMESTAMP_INSERT_ENABLE_BIT];
      end
      if (hit(reg_addr_i, serial_link_pkg::ADDR_LINK_SUBSYSTEM_ENABLE)) begin
        link_subsystem_enable_next =
          reg_wdata_i[serial_link_pkg::LINK_SUBSYSTEM_ENABLE_BIT];
      end
      if (hit(reg_addr_i, serial_link_pkg::ADDR_LINK_OUTPUT_MODE)) begin
        link_output_mode_next =
          reg_wdata_i[serial_link_pkg::LINK_OUTPUT_MODE_W-1:0];
      end
      if (hit(reg_addr_i,
              serial_link_pkg::ADDR_MULTIFRAME_LENGTH_MINUS_ONE)) begin
        multiframe_length_minus_one_next = reg_wdata_i;
      end
      // write one to clear the sticky ordering flag
      if (hit(reg_addr_i, serial_link_pkg::ADDR_LINK_STATUS) &&
          reg_wdata_i[serial_link_pkg::STATUS_ORDER_ERROR_BIT]) begin
        order_error_next = 1'b0;
      end
    end
    // ordering slips by software; a new slip wins over a clear
    if ((link_subsystem_enable_next && !link_subsystem_enable_reg &&
         !cal_enable_i) ||
        (link_subsystem_enable_reg && cal_enable_d_reg &&
         !cal_enable_i)) begin
      order_error_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      timestamp_insert_enable_reg     <=
        serial_link_pkg::TIMESTAMP_INSERT_ENABLE_RST;
      link_subsystem_enable_reg       <=
        serial_link_pkg::LINK_SUBSYSTEM_ENABLE_RST;
      link_output_mode_reg            <= serial_link_pkg::LINK_OUTPUT_MODE_RST;
      multiframe_length_minus_one_reg <=
        serial_link_pkg::MULTIFRAME_LENGTH_M1_RST;
      order_error_reg                 <= 1'b0;
      cal_enable_d_reg                <= 1'b0;
    end else begin
      timestamp_insert_enable_reg     <= timestamp_insert_enable_next;
      link_subsystem_enable_reg       <= link_subsystem_enable_next;
      link_output_mode_reg            <= link_output_mode_next;
      multiframe_length_minus_one_reg <= multiframe_length_minus_one_next;
      order_error_reg                 <= order_error_next;
      cal_enable_d_reg                <= cal_enable_i;
    end
  end

  // read data, valid only in the cycle after the strobe
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd_i) begin
      if (hit(reg_addr_i, serial_link_pkg::ADDR_TIMESTAMP_LSB_CONTROL)) begin
        rdata_next[serial_link_pkg::TIMESTAMP_INSERT_ENABLE_BIT] =
          timestamp_insert_enable_reg;
      end
      if (hit(reg_addr_i, serial_link_pkg::ADDR_LINK_SUBSYSTEM_ENABLE)) begin
        rdata_next[serial_link_pkg::LINK_SUBSYSTEM_ENABLE_BIT] =
          link_subsystem_enable_reg;
      end
      if (hit(reg_addr_i, serial_link_pkg::ADDR_LINK_OUTPUT_MODE)) begin
        rdata_next[serial_link_pkg::LINK_OUTPUT_MODE_W-1:0] =
          link_output_mode_reg;
      end
      if (hit(reg_addr_i,
              serial_link_pkg::ADDR_MULTIFRAME_LENGTH_MINUS_ONE)) begin
        rdata_next = multiframe_length_minus_one_reg;
      end
      if (hit(reg_addr_i, serial_link_pkg::ADDR_LINK_STATUS)) begin
        rdata_next[serial_link_pkg::STATUS_RUNNING_BIT] =
          (state_reg == serial_link_pkg::ST_RUNNING);
        rdata_next[serial_link_pkg::STATUS_ORDER_ERROR_BIT] = order_error_reg;
        rdata_next[serial_link_pkg::STATUS_DISABLED_BIT] =
          (state_reg == serial_link_pkg::ST_DISABLED);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // link state: held in reset while disabled, one start cycle on release
  always_comb begin
    state_next       = state_reg;
    active_mode_next = active_mode_reg;
    active_k_next    = active_k_reg;
    case (state_reg)
      serial_link_pkg::ST_DISABLED: begin
        if (link_subsystem_enable_reg) begin
          // mode frozen here; k a cycle later, once the decode sees it
          active_mode_next = link_output_mode_reg;
          state_next       = serial_link_pkg::ST_STARTING;
        end
      end
      serial_link_pkg::ST_STARTING: begin
        active_k_next = mode_is_64b66b_i
                      ? k_from_ef(mode_e_i, mode_f_i)
                      : serial_link_pkg::K_W'(
                          multiframe_length_minus_one_reg);
        state_next = link_subsystem_enable_reg
                   ? serial_link_pkg::ST_RUNNING
                   : serial_link_pkg::ST_DISABLED;
      end
      serial_link_pkg::ST_RUNNING: begin
        if (!link_subsystem_enable_reg) begin
          state_next = serial_link_pkg::ST_DISABLED;
        end
      end
      default: begin
        state_next = serial_link_pkg::ST_DISABLED;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg       <= serial_link_pkg::ST_DISABLED;
      active_mode_reg <= serial_link_pkg::LINK_OUTPUT_MODE_RST;
      active_k_reg    <= serial_link_pkg::K_W'(
                           serial_link_pkg::MULTIFRAME_LENGTH_M1_RST);
    end else begin
      state_reg       <= state_next;
      active_mode_reg <= active_mode_next;
      active_k_reg    <= active_k_next;
    end
  end

  // subsystem controls follow the state directly
  assign link_reset_o           =
    (state_reg == serial_link_pkg::ST_DISABLED);
  assign serializer_powerdown_o =
    (state_reg == serial_link_pkg::ST_DISABLED);
  assign link_clock_enable_o    =
    (state_reg != serial_link_pkg::ST_DISABLED);
  assign lmfc_counter_reset_o   =
    (state_reg == serial_link_pkg::ST_DISABLED);
  assign sysref_align_enable_o  =
    (state_reg != serial_link_pkg::ST_DISABLED);
  assign link_start_o           =
    (state_reg == serial_link_pkg::ST_STARTING);
  assign link_output_mode_o     = active_mode_reg;
  assign effective_k_minus_one_o = active_k_reg;
  assign ilas_control_bits_o    = serial_link_pkg::ILAS_CONTROL_BITS;
  assign reg_rdata_o            = rdata_reg;

  // timestamp pin comes from outside, so two flops before any use
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= timestamp_pin_i;
      sync2_reg <= sync1_reg;
    end
  end

  // delay set so the marker meets the sample it was taken with
  ts_delay_line #(
    .DEPTH (TS_DELAY)
  ) u_ts_delay (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       (sync2_reg & timestamp_receiver_enable_i),
    .q_o       (ts_delayed)
  );

  // converter bits sit above the N-bit field's LSB when N is wider
  generate
    if (SAMPLE_N > ADC_W) begin : gen_wide
      assign sample_placed = {sample_i, {(SAMPLE_N-ADC_W){1'b0}}};
    end else begin : gen_equal
      assign sample_placed = SAMPLE_N'(sample_i);
    end
  endgenerate

  // output sample; the marker replaces only the field's LSB
  always_comb begin
    sample_next       = sample_placed;
    sample_valid_next = sample_valid_i &&
                        (state_reg == serial_link_pkg::ST_RUNNING);
    if (timestamp_insert_enable_reg) begin
      sample_next[0] = ts_delayed;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sample_reg       <= '0;
      sample_valid_reg <= 1'b0;
    end else begin
      sample_reg       <= sample_next;
      sample_valid_reg <= sample_valid_next;
    end
  end

  assign sample_o       = sample_reg;
  assign sample_valid_o = sample_valid_reg;

endmodule
`default_nettype wire

//--- src/serial_link_pkg.sv
package serial_link_pkg;

  // register byte addresses on the 12-bit register port
  localparam logic [11:0] ADDR_TIMESTAMP_LSB_CONTROL       = 12'h160;
  localparam logic [11:0] ADDR_LINK_SUBSYSTEM_ENABLE       = 12'h200;
  localparam logic [11:0] ADDR_LINK_OUTPUT_MODE            = 12'h201;
  localparam logic [11:0] ADDR_MULTIFRAME_LENGTH_MINUS_ONE = 12'h202;
  localparam logic [11:0] ADDR_LINK_STATUS                 = 12'h210;

  // field positions and widths
  localparam int TIMESTAMP_INSERT_ENABLE_BIT = 0;
  localparam int LINK_SUBSYSTEM_ENABLE_BIT   = 0;
  localparam int LINK_OUTPUT_MODE_W          = 6;
  localparam int STATUS_RUNNING_BIT          = 0;
  localparam int STATUS_ORDER_ERROR_BIT      = 1;
  localparam int STATUS_DISABLED_BIT         = 2;

  // reset values
  localparam logic       TIMESTAMP_INSERT_ENABLE_RST = 1'b0;
  localparam logic       LINK_SUBSYSTEM_ENABLE_RST   = 1'b1;
  localparam logic [5:0] LINK_OUTPUT_MODE_RST        = 6'h00;
  localparam logic [7:0] MULTIFRAME_LENGTH_M1_RST    = 8'h1F;

  // link layer constants
  localparam logic [1:0] ILAS_CONTROL_BITS       = 2'h0;
  localparam int         K_W                     = 12;
  localparam int         K_64B66B_SCALE          = 256;

  // timing of the timestamp path
  localparam int TIMESTAMP_SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    ST_DISABLED,
    ST_STARTING,
    ST_RUNNING
  } link_state_t;

endpackage

//--- src/ts_delay_line.sv
`timescale 1ns/10ps
`default_nettype none
// shift register that lines the timestamp up with the sample pipeline
module ts_delay_line #(
  parameter int DEPTH = 4
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic [DEPTH-1:0] stage_reg;
  logic [DEPTH-1:0] stage_next;

  // each stage takes its neighbour, first stage takes the input
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : gen_stage
      if (g == 0) begin : gen_first
        assign stage_next[g] = d_i;
      end else begin : gen_rest
        assign stage_next[g] = stage_reg[g-1];
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      stage_reg <= '0;
    end else begin
      stage_reg <= stage_next;
    end
  end

  assign q_o = stage_reg[DEPTH-1];

endmodule
`default_nettype wire
